// ===== hdl/dcr_config_regs.v
// configuration register bank of a dual converter: paging, scratch, power-down, tx masks
`timescale 1ns/10ps
`include "dcr_consts.vh"


module dcr_config_regs #(
	parameter [3:0] GRADE_CODE    = 4'h2, // arbitrary value
	parameter [3:0] REVISION_CODE = 4'h1  // arbitrary value
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        clk_en,
	input  wire [11:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata_ff,
	output wire        paged_hit,
	output wire        paged_wr_ch0,
	output wire        paged_wr_ch1,
	output wire        paged_rd_ch1,
	input  wire        transmit_enable_pin_0,
	input  wire        transmit_enable_pin_1,
	output reg         reference_power_down_ff,
	output reg         master_bias_power_down_ff,
	output reg         channel0_down_ff,
	output reg         channel1_down_ff
);

	// ==========================================================
	// reset release
	reg rst_meta_ff;
	reg rst_sync_ff;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	wire rst_int_n = rst_sync_ff;

	// ==========================================================
	// helpers
	function in_range;
		input [11:0] a;
		input [11:0] lo;
		input [11:0] hi;
		begin
			in_range = (a >= lo) && (a <= hi);
		end
	endfunction

	function is_paged;
		input [11:0] a;
		begin
			is_paged = in_range(a, `DCR_PG_A_LO, `DCR_PG_A_HI) |
				in_range(a, `DCR_PG_B_LO, `DCR_PG_B_HI) |
				in_range(a, `DCR_PG_C_LO, `DCR_PG_C_HI) |
				in_range(a, `DCR_PG_D_LO, `DCR_PG_D_HI);
		end
	endfunction

	// ==========================================================
	// software registers
	reg [1:0] page_ff;
	reg [7:0] scratch_ff;
	reg       ref_pd_ff;
	reg       ch0_pd_ff;
	reg       ch1_pd_ff;
	reg       bias_pd_ff;
	reg [1:0] mask_ff;

	wire wr_page    = reg_wr && (reg_addr == `DCR_OFS_PAGE);
	wire wr_scratch = reg_wr && (reg_addr == `DCR_OFS_SCRATCH);
	wire wr_pwr     = reg_wr && (reg_addr == `DCR_OFS_PWR_CTRL);
	wire wr_mask    = reg_wr && (reg_addr == `DCR_OFS_TX_MASK);

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			page_ff    <= `DCR_RST_PAGE;
			scratch_ff <= `DCR_RST_SCRATCH;
			ref_pd_ff  <= `DCR_RST_REF_PD;
			ch0_pd_ff  <= `DCR_RST_CH0_PD;
			ch1_pd_ff  <= `DCR_RST_CH1_PD;
			bias_pd_ff <= `DCR_RST_BIAS_PD;
			mask_ff    <= `DCR_RST_MASK;
		end else if (clk_en) begin
			if (wr_page) begin
				page_ff <= reg_wdata[1:0];
			end
			// scratch feeds only the read mux
			if (wr_scratch) begin
				scratch_ff <= reg_wdata;
			end
			if (wr_pwr) begin
				ref_pd_ff  <= reg_wdata[`DCR_PWR_REF_BIT];
				ch0_pd_ff  <= reg_wdata[`DCR_PWR_CH0_BIT];
				ch1_pd_ff  <= reg_wdata[`DCR_PWR_CH1_BIT];
				bias_pd_ff <= reg_wdata[`DCR_PWR_BIAS_BIT];
			end
			// reserved mask bits are not stored and read back as zero
			if (wr_mask) begin
				mask_ff[`DCR_MASK_CH1_BIT] <= reg_wdata[`DCR_MASK_CH1_BIT];
				mask_ff[`DCR_MASK_CH0_BIT] <= reg_wdata[`DCR_MASK_CH0_BIT];
			end
		end
	end

	// ==========================================================
	// page steering toward the per-channel register files
	// the paged registers live in the channel files; only the strobes leave here
	wire pg = is_paged(reg_addr);

	assign paged_hit    = pg;
	assign paged_wr_ch0 = pg && reg_wr && page_ff[0];
	assign paged_wr_ch1 = pg && reg_wr && page_ff[1];
	// broadcast reads come from channel 0
	assign paged_rd_ch1 = pg && (page_ff == `DCR_PAGE_CH1);

	// ==========================================================
	// read path, one cycle after the strobe
	reg [7:0] nxt_rdata;

	always @* begin
		nxt_rdata = 8'h00;
		case (reg_addr)
			`DCR_OFS_GRADE_REV: nxt_rdata = {GRADE_CODE, REVISION_CODE};
			`DCR_OFS_PAGE:      nxt_rdata = {6'h00, page_ff};
			`DCR_OFS_SCRATCH:   nxt_rdata = scratch_ff;
			`DCR_OFS_PWR_CTRL:  nxt_rdata = {ref_pd_ff, ch0_pd_ff, 1'b0, ch1_pd_ff,
				1'b0, bias_pd_ff, 2'h0};
			`DCR_OFS_TX_MASK:   nxt_rdata = {6'h00, mask_ff};
			default:            nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			reg_rdata_ff <= 8'h00;
		end else if (clk_en && reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================
	// transmit-enable pins: synchronise, then catch the falling edge
	reg [1:0] tx_meta_ff;
	reg [1:0] tx_sync_ff;
	reg [1:0] tx_prev_ff;
	reg [1:0] tx_down_ff;
	reg [1:0] nxt_tx_down;

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			tx_meta_ff <= 2'h3;
			tx_sync_ff <= 2'h3;
			tx_prev_ff <= 2'h3;
		end else if (clk_en) begin
			tx_meta_ff <= {transmit_enable_pin_1, transmit_enable_pin_0};
			tx_sync_ff <= tx_meta_ff;
			tx_prev_ff <= tx_sync_ff;
		end
	end

	// edge-triggered on purpose: setting a mask while the pin is already low does not
	// power down; the hold then lasts until the pin rises or the mask is cleared
	always @* begin
		nxt_tx_down = tx_down_ff & mask_ff & ~tx_sync_ff;
		if (mask_ff[`DCR_MASK_CH1_BIT] && tx_prev_ff[1] && !tx_sync_ff[1]) begin
			nxt_tx_down[1] = 1'b1;
		end
		if (mask_ff[`DCR_MASK_CH0_BIT] && tx_prev_ff[0] && !tx_sync_ff[0]) begin
			nxt_tx_down[0] = 1'b1;
		end
	end

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			tx_down_ff <= 2'h0;
		end else if (clk_en) begin
			tx_down_ff <= nxt_tx_down;
		end
	end

	// ==========================================================
	// effective power-down levels
	wire common_pd = ref_pd_ff | bias_pd_ff;

	always @(posedge clock or negedge rst_int_n) begin
		if (!rst_int_n) begin
			reference_power_down_ff   <= `DCR_RST_REF_PD;
			master_bias_power_down_ff <= `DCR_RST_BIAS_PD;
			channel0_down_ff          <= 1'b1;
			channel1_down_ff          <= 1'b1;
		end else if (clk_en) begin
			reference_power_down_ff   <= ref_pd_ff;
			master_bias_power_down_ff <= bias_pd_ff;
			channel0_down_ff          <= ch0_pd_ff | common_pd | tx_down_ff[0];
			channel1_down_ff          <= ch1_pd_ff | common_pd | tx_down_ff[1];
		end
	end

endmodule

// ===== hdl/dcr_consts.vh
// constants for the dual converter configuration register bank
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH

// ==========================================================
// register offsets
`define DCR_ADDR_W          12
`define DCR_OFS_GRADE_REV   12'h006
`define DCR_OFS_PAGE        12'h008
`define DCR_OFS_SCRATCH     12'h00a
`define DCR_OFS_PWR_CTRL    12'h011
`define DCR_OFS_TX_MASK     12'h012

// ==========================================================
// paged ranges, inclusive
`define DCR_PG_A_LO         12'h013
`define DCR_PG_A_HI         12'h014
`define DCR_PG_B_LO         12'h034
`define DCR_PG_B_HI         12'h03d
`define DCR_PG_C_LO         12'h110
`define DCR_PG_C_HI         12'h124
`define DCR_PG_D_LO         12'h135
`define DCR_PG_D_HI         12'h14c

// ==========================================================
// page codes
`define DCR_PAGE_CH0        2'h1
`define DCR_PAGE_CH1        2'h2
`define DCR_PAGE_BOTH       2'h3

// ==========================================================
// field positions
`define DCR_PWR_REF_BIT     7
`define DCR_PWR_CH0_BIT     6
`define DCR_PWR_CH1_BIT     4
`define DCR_PWR_BIAS_BIT    2
`define DCR_MASK_CH1_BIT    1
`define DCR_MASK_CH0_BIT    0

// ==========================================================
// reset values
`define DCR_RST_PAGE        2'h3
`define DCR_RST_SCRATCH     8'h00
`define DCR_RST_REF_PD      1'b0
`define DCR_RST_CH0_PD      1'b1
`define DCR_RST_CH1_PD      1'b1
`define DCR_RST_BIAS_PD     1'b1
`define DCR_RST_MASK        2'h0

`endif

// ===== tb/dcr_host.sv
// host model driving the byte register port
`timescale 1ns/10ps
module dcr_host (
	input  wire        clock,
	output reg  [11:0] reg_addr,
	output reg  [7:0]  reg_wdata,
	output reg         reg_wr,
	output reg         reg_rd
);
initial begin
	reg_addr = 12'h000;
	reg_wdata = 8'h00;
	reg_wr = 1'b0;
	reg_rd = 1'b0;
end
// one byte per access; data inverted after use so stale bytes never match
task acc(input w, input [11:0] a, input [7:0] d);
	@(posedge clock);
	#1;
	reg_addr = a;
	reg_wdata = d;
	reg_wr = w;
	reg_rd = !w;
	@(posedge clock);
	#1;
	reg_wr = 1'b0;
	reg_rd = 1'b0;
	reg_wdata = ~d;
endtask
endmodule

// ===== tb/dcr_regs_chk_sva.sv
// port checker for the configuration register bank
`timescale 1ns/10ps
module dcr_regs_chk (
	input wire        clock,
	input wire        rst_n,
	input wire [11:0] reg_addr,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata_ff,
	input wire        paged_hit,
	input wire        paged_wr_ch0,
	input wire        paged_wr_ch1,
	input wire        paged_rd_ch1,
	input wire        reference_power_down_ff,
	input wire        master_bias_power_down_ff,
	input wire        channel0_down_ff,
	input wire        channel1_down_ff
);
// ==========
// properties
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
sequence s_rd(a);
	reg_rd && reg_addr == a;
endsequence
// two cycles of reference or bias power-down; the channel flops update on the same edge as those flops
sequence s_off;
	(reference_power_down_ff || master_bias_power_down_ff) [*2];
endsequence
chk_page_hit:
	assert property (paged_hit == (reg_addr inside {[12'h013:12'h014], [12'h034:12'h03d],
		[12'h110:12'h124], [12'h135:12'h14c]})) else $error("paged decode wrong");
chk_wr_gate:
	assert property ((paged_wr_ch0 || paged_wr_ch1) |-> reg_wr && paged_hit)
	else $error("paged write without cause");
chk_rd_sel:
	assert property (paged_rd_ch1 |-> paged_hit && !paged_wr_ch0) else $error("read select");
chk_rd_follow:
	assert property (paged_hit && reg_wr |-> paged_rd_ch1 == (paged_wr_ch1 && !paged_wr_ch0))
	else $error("paged read channel");
chk_off_down:
	assert property (s_off |-> channel0_down_ff && channel1_down_ff)
	else $error("channel up without bias");
chk_rd_hold:
	assert property (!reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved");
chk_page_rsv:
	assert property (s_rd(12'h008) |=> reg_rdata_ff[7:2] == 6'h00) else $error("page rsv");
chk_pwr_rsv:
	assert property (s_rd(12'h011) |=> (reg_rdata_ff & 8'h2b) == 8'h00) else $error("pwr rsv");
chk_mask_rsv:
	assert property (s_rd(12'h012) |=> reg_rdata_ff[7:2] == 6'h00) else $error("mask rsv");
endmodule
bind dcr_config_regs dcr_regs_chk u_chk (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata_ff, .paged_hit, .paged_wr_ch0, .paged_wr_ch1, .paged_rd_ch1,
	.reference_power_down_ff, .master_bias_power_down_ff, .channel0_down_ff, .channel1_down_ff);

// ===== tb/dual_converter_config_regs_test.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
module dual_converter_config_regs_test;
reg          clock = 1'b0;
reg          rst_n = 1'b0;
reg          pin0 = 1'b1;
reg          pin1 = 1'b1;
reg          en = 1'b1;
wire [11:0]  reg_addr;
wire [7:0]   reg_wdata, rdata;
wire         reg_wr, reg_rd, hit, wr0, wr1, rd1, ref_pd, bias_pd, ch0, ch1;
int          bad_count = 0;
int          comparisons = 0;
logic [7:0]  exp_q[$];
logic        pend = 1'b0;
logic [1:0]  wcap = 2'h0;
logic [31:0] seed = 32'h65d0a8aa;
always #12.5 clock = ~clock;
dcr_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd));
dcr_config_regs u_dut (.clock(clock), .rst_n(rst_n), .clk_en(en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
	.paged_hit(hit), .paged_wr_ch0(wr0), .paged_wr_ch1(wr1), .paged_rd_ch1(rd1),
	.transmit_enable_pin_0(pin0), .transmit_enable_pin_1(pin1),
	.reference_power_down_ff(ref_pd), .master_bias_power_down_ff(bias_pd),
	.channel0_down_ff(ch0), .channel1_down_ff(ch1));
// ==========
// checking
task chk(input [7:0] seen, input [7:0] exp);
	comparisons++;
	if (seen !== exp) begin
		bad_count++;
		$display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
	end
endtask
task final_report;
	$display("comparisons %0d mismatches %0d", comparisons, bad_count);
	if (bad_count == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
always @(negedge clock) begin
	if (pend)
		chk(rdata, exp_q.pop_front());
	pend = reg_rd;
	if (reg_wr)
		wcap = {wr1, wr0};
end
// ==========
// stimulus
function [31:0] xs(input [31:0] s);
	xs = s ^ (s << 13);
	xs = xs ^ (xs >> 17);
	xs = xs ^ (xs << 5);
endfunction
task rd(input [11:0] a, input [7:0] e);
	exp_q.push_back(e);
	u_host.acc(1'b0, a, 8'h00);
endtask
task pw(input [7:0] v, input [3:0] e);
	u_host.acc(1'b1, 12'h011, v);
	repeat (2) @(posedge clock);
	#2;
	chk({4'h0, ref_pd, bias_pd, ch1, ch0}, {4'h0, e});
endtask
task pin(input [1:0] v, input [3:0] e);
	@(posedge clock);
	#1;
	{pin1, pin0} = v;
	repeat (6) @(posedge clock);
	#2;
	chk({4'h0, ref_pd, bias_pd, ch1, ch0}, {4'h0, e});
endtask
initial begin
	#100000;
	bad_count++;
	final_report;
end
initial begin
	repeat (10) @(posedge clock);
	#1 rst_n = 1'b1;
	repeat (3) @(posedge clock);
	rd(12'h008, 8'h03);
	rd(12'h00a, 8'h00);
	rd(12'h011, 8'h54);
	rd(12'h012, 8'h00);
	rd(12'h006, 8'h21);
	rd(12'h7ff, 8'h00);
	$display("test reset done");
	seed = xs(seed);
	u_host.acc(1'b1, 12'h00a, seed[7:0]);
	rd(12'h00a, seed[7:0]);
	rd(12'h008, 8'h03);
	chk({4'h0, ref_pd, bias_pd, ch1, ch0}, 8'h07);
	// clock enable low: this write must be frozen out
	en = 1'b0;
	u_host.acc(1'b1, 12'h00a, ~seed[7:0]);
	en = 1'b1;
	rd(12'h00a, seed[7:0]);
	$display("test scratch done");
	for (int p = 1; p < 4; p++) begin
		u_host.acc(1'b1, 12'h008, {6'h3f, p[1:0]});
		rd(12'h008, {6'h00, p[1:0]});
		u_host.acc(1'b1, 12'h14c, 8'h00);
		chk({4'h0, hit, rd1, wcap}, {4'h0, 1'b1, p == 2, p[1:0]});
		u_host.acc(1'b1, 12'h14d, 8'h00);
		chk({5'h00, hit, wcap}, 8'h00);
	end
	$display("test paging done");
	pw(8'h00, 4'h0);
	pw(8'h80, 4'hb);
	pw(8'h04, 4'h7);
	pw(8'h40, 4'h1);
	pw(8'h10, 4'h2);
	pw(8'h00, 4'h0);
	$display("test power done");
	u_host.acc(1'b1, 12'h012, 8'h03);
	pin(2'b10, 4'h1);
	pin(2'b00, 4'h3);
	pin(2'b00, 4'h3);
	pin(2'b01, 4'h2);
	pin(2'b11, 4'h0);
	$display("test mask done");
	final_report;
end
endmodule
